// file: core/dcff_top.sv
// Dual-clock FIFO with full, empty, almost and half-full flags and threshold registers
`timescale 1ns/1ps
`include "dcff_params.svh"

// What this block does
// - Reset returns write and read pointers to the first location.
// - Reset: full, half, almost-full high; empty, almost-empty low; output zero; thresholds default.
// - Write edge with enable low, select high, not full stores the word.
// - Writes ignored while full; full flag moves only on write edges.
// - Read edge with enable low, select high, not empty loads output register.
// - No fall-through: every word needs a read request to appear.
// - Empty flag goes low after last read, updates only on read edges.
// - Output enable low raises the data enable output; high lowers it so the bus floats outside.
// - Two 12-bit thresholds written from low data bits, read on outputs.
// - Select and write enable low: write empty, then full, then wrap.
// - Select high resumes normal work; next threshold write continues sequence.
// - Select low, write enable high: write edges do nothing.
// - Select and read enable low: read edges show thresholds alternately.
// - Full flag falls after exactly depth writes without reads.
// - Almost-full low once count reaches depth minus full threshold.
// - Almost-full set on write edges, released on read edges.
// - Almost-empty low while count is empty threshold or fewer.
// - Almost-empty set on read edges, released on write edges.
// - Chain inputs low: push chain output is half-full, low above half.
// - Half-full falls on write edge past half, rises on read edge.
// - Chain mode: pulse chain outputs on last-location write or read.
module dcff_top
    import dcff_pkg::*;
(
    input  wire logic                    CLK,
    input  wire logic                    RSTN,
    input  wire logic                    WCLK,
    input  wire logic                    RCLK,
    input  wire logic                    CLEAR_IN_N,
    input  wire logic                    WRITE_ENABLE_N,
    input  wire logic                    READ_ENABLE_N,
    input  wire logic                    THRESHOLD_SELECT_N,
    input  wire logic                    OUTPUT_ENABLE_N,
    input  wire logic                    CHAIN_HEAD_N,
    input  wire logic                    PUSH_CHAIN_IN_N,
    input  wire logic                    POP_CHAIN_IN_N,
    input  wire logic [`DCFF_DATA_W-1:0] WRITE_DATA,
    output logic      [`DCFF_DATA_W-1:0] READ_DATA,
    output logic                         READ_DATA_OE,
    output logic                         FULL_N,
    output logic                         EMPTY_N,
    output logic                         ALMOST_FULL_N,
    output logic                         ALMOST_EMPTY_N,
    output logic                         PUSH_CHAIN_OUT_N,
    output logic                         POP_CHAIN_OUT_N
);
    dcff_state_t               q;
    dcff_state_t               d;
    dcff_pins_t                pins;
    logic [`DCFF_DATA_W-1:0]   mem_q [`DCFF_DEPTH];
    logic                      st_in_valid;
    logic                      st_in_ready;
    logic                      st_out_valid;
    logic                      st_out_ready;
    dcff_stage_t               st_in;
    dcff_stage_t               st_out;
    logic                      wedge;
    logic                      redge;
    logic                      wr_go;
    logic                      rd_go;
    logic                      chain_mode;

    // Binary to Gray and back for pointers crossing sides
    function automatic logic [`DCFF_PTR_W-1:0] to_gray(input logic [`DCFF_PTR_W-1:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [`DCFF_PTR_W-1:0] from_gray(input logic [`DCFF_PTR_W-1:0] g);
        logic [`DCFF_PTR_W-1:0] b;
        b = '0;
        b[`DCFF_PTR_W-1] = g[`DCFF_PTR_W-1];
        for (int i = `DCFF_PTR_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // FIFO contents and pointer synchronisers to their cleared values, pin synchroniser stages untouched
    function automatic dcff_state_t clear_fifo(input dcff_state_t s);
        dcff_state_t r;
        r          = s;
        r.wptr     = '0;
        r.wdone    = '0;
        r.rptr     = '0;
        r.wgray    = '0;
        r.rgray    = '0;
        r.wg_s1    = '0;
        r.wg_s2    = '0;
        r.rg_s1    = '0;
        r.rg_s2    = '0;
        r.empty_th = `DCFF_EMPTY_TH_RST;
        r.full_th  = `DCFF_FULL_TH_RST;
        r.wsel     = 1'b0;
        r.rsel     = 1'b0;
        r.out      = '0;
        r.full_n   = 1'b1;
        r.af_n     = 1'b1;
        r.hf_n     = 1'b1;
        r.empty_n  = 1'b0;
        r.ae_n     = 1'b0;
        r.wxo_n    = 1'b1;
        r.rxo_n    = 1'b1;
        return r;
    endfunction

    // Pin bundle before the synchroniser
    always_comb begin
        pins       = '0;
        pins.wclk  = WCLK;
        pins.rclk  = RCLK;
        pins.clr_n = CLEAR_IN_N;
        pins.wen_n = WRITE_ENABLE_N;
        pins.ren_n = READ_ENABLE_N;
        pins.ld_n  = THRESHOLD_SELECT_N;
        pins.oe_n  = OUTPUT_ENABLE_N;
        pins.fl_n  = CHAIN_HEAD_N;
        pins.wxi_n = PUSH_CHAIN_IN_N;
        pins.rxi_n = POP_CHAIN_IN_N;
        pins.data  = WRITE_DATA;
    end

    // Port clocks become one-cycle enables; data rides the same two stages as its strobes
    assign wedge      = q.s2.wclk & ~q.wclk_prev;
    assign redge      = q.s2.rclk & ~q.rclk_prev;
    assign chain_mode = q.s2.wxi_n | q.s2.rxi_n;
    assign wr_go      = wedge & q.s2.ld_n & ~q.s2.wen_n & q.full_n & st_in_ready;
    assign rd_go      = redge & q.s2.ld_n & ~q.s2.ren_n & q.empty_n;

    // Staged array write; the array port yields to a read so the stage can fill
    assign st_in_valid  = wr_go;
    assign st_in.addr   = q.wptr[`DCFF_ADDR_W-1:0];
    assign st_in.data   = q.s2.data;
    assign st_out_ready = ~rd_go;

    dcff_stage_fifo #(
        .WIDTH (`DCFF_STAGE_W),
        .DEPTH (`DCFF_STAGE_DEPTH)
    ) u_stage (
        .clk       (CLK),
        .rst_n     (RSTN),
        .in_valid  (st_in_valid),
        .in_ready  (st_in_ready),
        .in_data   (st_in),
        .out_valid (st_out_valid),
        .out_ready (st_out_ready),
        .out_data  (st_out)
    );

    // Array write from the stage
    always_ff @(posedge CLK) begin
        if (st_out_valid & st_out_ready) begin
            mem_q[st_out.addr] <= st_out.data;
        end
    end

    // Next state
    always_comb begin
        logic [`DCFF_PTR_W-1:0] rsync;
        logic [`DCFF_PTR_W-1:0] wsync;
        logic [`DCFF_PTR_W-1:0] wptr_n;
        logic [`DCFF_PTR_W-1:0] rptr_n;
        logic [`DCFF_CNT_W-1:0] wcnt;
        logic [`DCFF_CNT_W-1:0] rcnt;
        logic [`DCFF_CNT_W-1:0] af_lvl;
        logic [`DCFF_CNT_W-1:0] ae_lvl;
        logic                   af_hit;
        logic                   hf_hit;
        rsync  = from_gray(q.rg_s2);
        wsync  = from_gray(q.wg_s2);
        wptr_n = q.wptr + `DCFF_PTR_W'(wr_go);
        rptr_n = q.rptr + `DCFF_PTR_W'(rd_go);
        wcnt   = `DCFF_CNT_W'(`DCFF_PTR_W'(wptr_n - rsync));
        rcnt   = `DCFF_CNT_W'(`DCFF_PTR_W'(wsync - rptr_n));
        af_lvl = `DCFF_DEPTH_CNT - `DCFF_CNT_W'(q.full_th);
        ae_lvl = `DCFF_CNT_W'(q.empty_th);
        // Write-side set and read-side release in one cycle: the set wins
        af_hit = wedge & q.s2.ld_n & (wcnt >= af_lvl);
        hf_hit = wedge & q.s2.ld_n & ~chain_mode & (wcnt > `DCFF_HALF_CNT);
        d      = q;

        // Two-stage synchronisers; stage one feeds stage two only
        d.s1        = pins;
        d.s2        = q.s1;
        d.wclk_prev = q.s2.wclk;
        d.rclk_prev = q.s2.rclk;

        // Gray pointers published and carried across sides
        d.wgray = to_gray(q.wdone);
        d.rgray = to_gray(q.rptr);
        d.wg_s1 = q.wgray;
        d.wg_s2 = q.wg_s1;
        d.rg_s1 = q.rgray;
        d.rg_s2 = q.rg_s1;

        // Read side sees only words already in the array
        if (st_out_valid & st_out_ready) begin
            d.wdone = q.wdone + `DCFF_PTR_W'(1);
        end

        // Chain pulses default released
        d.wxo_n = 1'b1;
        d.rxo_n = 1'b1;

        // Write edge: store, or load a threshold, and refresh write-side flags
        if (wedge) begin
            if (q.s2.ld_n) begin
                d.wptr   = wptr_n;
                d.full_n = (wcnt != `DCFF_DEPTH_CNT);
                if (af_hit) begin
                    d.af_n = 1'b0;
                end
                if (wcnt > ae_lvl) begin
                    d.ae_n = 1'b1;
                end
                if (hf_hit) begin
                    d.hf_n = 1'b0;
                end
                if (chain_mode && wr_go && q.wptr[`DCFF_ADDR_W-1:0] == `DCFF_LAST_ADDR) begin
                    d.wxo_n = 1'b0;
                end
            end else if (!q.s2.wen_n) begin
                // Alternating threshold loads; selector survives select going high
                if (q.wsel) begin
                    d.full_th = q.s2.data[`DCFF_TH_W-1:0];
                end else begin
                    d.empty_th = q.s2.data[`DCFF_TH_W-1:0];
                end
                d.wsel = ~q.wsel;
            end
            // Select low with write enable high: edge has no effect
        end

        // Read edge: pop, or show a threshold, and refresh read-side flags
        if (redge) begin
            if (q.s2.ld_n) begin
                if (rd_go) begin
                    d.out  = mem_q[q.rptr[`DCFF_ADDR_W-1:0]];
                    d.rptr = rptr_n;
                end
                d.empty_n = (rcnt != '0);
                if (rcnt < af_lvl && !af_hit) begin
                    d.af_n = 1'b1;
                end
                if (rcnt <= ae_lvl) begin
                    d.ae_n = 1'b0;
                end
                if (rcnt <= `DCFF_HALF_CNT && !hf_hit) begin
                    d.hf_n = 1'b1;
                end
                if (chain_mode && rd_go && q.rptr[`DCFF_ADDR_W-1:0] == `DCFF_LAST_ADDR) begin
                    d.rxo_n = 1'b0;
                end
            end else if (!q.s2.ren_n) begin
                // Own read selector, independent of the load selector
                d.out  = q.rsel ? `DCFF_DATA_W'(q.full_th) : `DCFF_DATA_W'(q.empty_th);
                d.rsel = ~q.rsel;
            end
        end

        // Clear pin wins over everything; bus reset clears the synchronisers too
        if (!q.s2.clr_n) begin
            d = clear_fifo(d);
        end
        if (!RSTN) begin
            d = clear_fifo('0);
        end
    end

    // Single state register
    always_ff @(posedge CLK) begin
        q <= d;
    end

    // Outputs from flops; the enable floats the bus outside this module
    assign READ_DATA        = q.out;
    assign READ_DATA_OE     = ~q.s2.oe_n;
    assign FULL_N           = q.full_n;
    assign EMPTY_N          = q.empty_n;
    assign ALMOST_FULL_N    = q.af_n;
    assign ALMOST_EMPTY_N   = q.ae_n;
    assign PUSH_CHAIN_OUT_N = chain_mode ? q.wxo_n : q.hf_n;
    assign POP_CHAIN_OUT_N  = q.rxo_n;

endmodule // dcff_top

// file: core/dcff_params.svh
// Constants of the dual-clock flagged FIFO: sizes, reset values, counts
`ifndef DCFF_PARAMS_SVH
`define DCFF_PARAMS_SVH

// Word and array geometry (smallest depth option)
`define DCFF_DATA_W        18
`define DCFF_DEPTH         256
`define DCFF_ADDR_W        8
`define DCFF_PTR_W         9
`define DCFF_LAST_ADDR     8'hFF

// Threshold registers
`define DCFF_TH_W          12
`define DCFF_EMPTY_TH_RST  12'h001F
`define DCFF_FULL_TH_RST   12'h001F

// Word counts at 13 bits so that thresholds up to 4095 compare cleanly
`define DCFF_CNT_W         13
`define DCFF_DEPTH_CNT     13'h0100
`define DCFF_HALF_CNT      13'h0080

// Staging buffer between the write port and the array
`define DCFF_STAGE_DEPTH   4
`define DCFF_STAGE_W       26

`endif

// file: core/dcff_pkg.sv
// Types shared by the dual-clock flagged FIFO design
`include "dcff_params.svh"

package dcff_pkg;

    // Pin levels as sampled through the synchroniser
    typedef struct packed {
        logic                      wclk;
        logic                      rclk;
        logic                      clr_n;
        logic                      wen_n;
        logic                      ren_n;
        logic                      ld_n;
        logic                      oe_n;
        logic                      fl_n;
        logic                      wxi_n;
        logic                      rxi_n;
        logic [`DCFF_DATA_W-1:0]   data;
    } dcff_pins_t;

    // One staged array write: address and word
    typedef struct packed {
        logic [`DCFF_ADDR_W-1:0]   addr;
        logic [`DCFF_DATA_W-1:0]   data;
    } dcff_stage_t;

    // Whole state of the top module apart from the array
    typedef struct packed {
        dcff_pins_t                s1;
        dcff_pins_t                s2;
        logic                      wclk_prev;
        logic                      rclk_prev;
        logic [`DCFF_PTR_W-1:0]    wptr;
        logic [`DCFF_PTR_W-1:0]    wdone;
        logic [`DCFF_PTR_W-1:0]    rptr;
        logic [`DCFF_PTR_W-1:0]    wgray;
        logic [`DCFF_PTR_W-1:0]    rgray;
        logic [`DCFF_PTR_W-1:0]    wg_s1;
        logic [`DCFF_PTR_W-1:0]    wg_s2;
        logic [`DCFF_PTR_W-1:0]    rg_s1;
        logic [`DCFF_PTR_W-1:0]    rg_s2;
        logic [`DCFF_TH_W-1:0]     empty_th;
        logic [`DCFF_TH_W-1:0]     full_th;
        logic                      wsel;
        logic                      rsel;
        logic [`DCFF_DATA_W-1:0]   out;
        logic                      full_n;
        logic                      empty_n;
        logic                      af_n;
        logic                      ae_n;
        logic                      hf_n;
        logic                      wxo_n;
        logic                      rxo_n;
    } dcff_state_t;

endpackage

// file: core/dcff_stage_fifo.sv
// Small valid/ready FIFO that stages writes on their way into the array
`timescale 1ns/1ps

module dcff_stage_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    head_q;
    logic [AW-1:0]    tail_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    // Honest flags straight from the occupancy count
    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[head_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Pointers wrap at depth; depth need not be a power of two
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            head_q <= '0;
            tail_q <= '0;
            cnt_q  <= '0;
        end else begin
            if (push) begin
                tail_q <= (tail_q == AW'(DEPTH - 1)) ? '0 : tail_q + AW'(1);
            end
            if (pop) begin
                head_q <= (head_q == AW'(DEPTH - 1)) ? '0 : head_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Storage carries no reset; only counted entries are ever read
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[tail_q] <= in_data;
        end
    end

endmodule // dcff_stage_fifo

// file: tb/dcff_top_properties.sv
// Port-level timing checks of the flagged dual-clock FIFO
`timescale 1ns/1ps

module dcff_top_properties (
    input wire logic        CLK,
    input wire logic        RSTN,
    input wire logic        WCLK,
    input wire logic        RCLK,
    input wire logic        CLEAR_IN_N,
    input wire logic        OUTPUT_ENABLE_N,
    input wire logic        PUSH_CHAIN_IN_N,
    input wire logic        POP_CHAIN_IN_N,
    input wire logic [17:0] READ_DATA,
    input wire logic        READ_DATA_OE,
    input wire logic        FULL_N,
    input wire logic        EMPTY_N,
    input wire logic        ALMOST_FULL_N,
    input wire logic        ALMOST_EMPTY_N,
    input wire logic        PUSH_CHAIN_OUT_N,
    input wire logic        POP_CHAIN_OUT_N
);
    logic       wclk_q;
    logic       rclk_q;
    logic [3:0] w_age;
    logic [3:0] r_age;
    logic [3:0] c_age;

    function automatic logic [3:0] sat(input logic [3:0] a);
        return (a == 4'hF) ? a : a + 4'h1;
    endfunction

    // Cycles since each port edge; saturating so stale edges never look fresh
    always_ff @(posedge CLK) begin
        wclk_q <= WCLK;
        rclk_q <= RCLK;
        if (!RSTN) begin
            w_age <= 4'hF;
            r_age <= 4'hF;
            c_age <= 4'h0;
        end else begin
            w_age <= (WCLK && !wclk_q) ? 4'h0 : sat(w_age);
            r_age <= (RCLK && !rclk_q) ? 4'h0 : sat(r_age);
            c_age <= !CLEAR_IN_N ? 4'h0 : sat(c_age);
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    // Clear also moves the flags, so each edge check waits out a recent clear
    property p_reset_flags;
        $rose(RSTN) |-> FULL_N && ALMOST_FULL_N && PUSH_CHAIN_OUT_N && !EMPTY_N && !ALMOST_EMPTY_N
            && READ_DATA == 18'h0_0000;
    endproperty
    a_reset_flags: assert property (p_reset_flags) else $error("flags not at reset level");
    property p_full_wedge; ($changed(FULL_N) && c_age > 4'h6) |-> w_age <= 4'h6; endproperty
    a_full_wedge: assert property (p_full_wedge) else $error("full moved off a write edge");
    property p_empty_redge; ($changed(EMPTY_N) && c_age > 4'h6) |-> r_age <= 4'h6; endproperty
    a_empty_redge: assert property (p_empty_redge) else $error("empty moved off a read edge");
    property p_af_side;
        ($changed(ALMOST_FULL_N) && c_age > 4'h6) |-> (ALMOST_FULL_N ? r_age <= 4'h6 : w_age <= 4'h6);
    endproperty
    a_af_side: assert property (p_af_side) else $error("almost full moved on wrong edge");
    property p_ae_side;
        ($changed(ALMOST_EMPTY_N) && c_age > 4'h6) |-> (ALMOST_EMPTY_N ? w_age <= 4'h6 : r_age <= 4'h6);
    endproperty
    a_ae_side: assert property (p_ae_side) else $error("almost empty moved on wrong edge");
    property p_hf_side;
        (!PUSH_CHAIN_IN_N && !POP_CHAIN_IN_N)[*6] ##0 ($changed(PUSH_CHAIN_OUT_N) && c_age > 4'h6)
            |-> (PUSH_CHAIN_OUT_N ? r_age <= 4'h6 : w_age <= 4'h6);
    endproperty
    a_hf_side: assert property (p_hf_side) else $error("half full moved on wrong edge");
    property p_rdata_redge; ($changed(READ_DATA) && c_age > 4'h6) |-> r_age <= 4'h6; endproperty
    a_rdata_redge: assert property (p_rdata_redge) else $error("output changed off a read edge");
    property p_oe_follow; $stable(OUTPUT_ENABLE_N)[*6] |-> READ_DATA_OE == !OUTPUT_ENABLE_N; endproperty
    a_oe_follow: assert property (p_oe_follow) else $error("output enable not followed");
    property p_pop_idle; (!PUSH_CHAIN_IN_N && !POP_CHAIN_IN_N)[*4] |-> POP_CHAIN_OUT_N; endproperty
    a_pop_idle: assert property (p_pop_idle) else $error("chain pulse outside chain mode");
    // Chain mode: each pulse lasts one cycle and follows its own port edge
    property p_push_pulse;
        (PUSH_CHAIN_IN_N || POP_CHAIN_IN_N)[*6] ##0 $fell(PUSH_CHAIN_OUT_N) |=> PUSH_CHAIN_OUT_N && w_age <= 4'h6;
    endproperty
    a_push_pulse: assert property (p_push_pulse) else $error("push chain pulse malformed");
    property p_pop_pulse;
        (PUSH_CHAIN_IN_N || POP_CHAIN_IN_N)[*6] ##0 $fell(POP_CHAIN_OUT_N) |=> POP_CHAIN_OUT_N && r_age <= 4'h6;
    endproperty
    a_pop_pulse: assert property (p_pop_pulse) else $error("pop chain pulse malformed");
endmodule // dcff_top_properties

bind dcff_top dcff_top_properties u_dcff_top_properties (
    .CLK(CLK), .RSTN(RSTN), .WCLK(WCLK), .RCLK(RCLK), .CLEAR_IN_N(CLEAR_IN_N),
    .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N), .PUSH_CHAIN_IN_N(PUSH_CHAIN_IN_N), .POP_CHAIN_IN_N(POP_CHAIN_IN_N),
    .READ_DATA(READ_DATA), .READ_DATA_OE(READ_DATA_OE), .FULL_N(FULL_N), .EMPTY_N(EMPTY_N),
    .ALMOST_FULL_N(ALMOST_FULL_N), .ALMOST_EMPTY_N(ALMOST_EMPTY_N),
    .PUSH_CHAIN_OUT_N(PUSH_CHAIN_OUT_N), .POP_CHAIN_OUT_N(POP_CHAIN_OUT_N));

// file: tb/dcff_port_model.sv
// Writer and reader logic driving the FIFO port clocks, strobes and data
`timescale 1ns/1ps

module dcff_port_model (
    input  wire logic  clk,
    output logic       wclk,
    output logic       rclk,
    output logic       wen_n,
    output logic       ren_n,
    output logic       sel_n,
    output logic [17:0] data
);
    // Port clocks idle low between cycles, not free running
    initial begin
        wclk  = 1'b0;
        rclk  = 1'b0;
        wen_n = 1'b1;
        ren_n = 1'b1;
        sel_n = 1'b1;
        data  = 18'h0_0000;
    end

    // One port cycle; calls run one after another, so no threshold read meets a write
    task automatic port_cycle(input logic is_wr, input logic s_n, input logic e_n, input logic [17:0] d);
        @(posedge clk);
        #1;
        sel_n = s_n;
        wen_n = is_wr ? e_n : 1'b1;
        ren_n = is_wr ? 1'b1 : e_n;
        data  = d;
        repeat (2) @(posedge clk);
        #1;
        wclk = is_wr;
        rclk = !is_wr;
        repeat (3) @(posedge clk);
        #1;
        wclk = 1'b0;
        rclk = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        wen_n = 1'b1;
        ren_n = 1'b1;
        // Hold time over: scramble data so a stale word cannot pass
        data  = ~data;
    endtask
endmodule // dcff_port_model

// file: tb/tb_top.sv
// Self-checking bench for the flagged dual-clock FIFO
`timescale 1ns/1ps

`define CHK(act, exp) \
    begin \
        total_checks++; \
        if ((act) !== (exp)) begin \
            err_total++; \
            $display("mismatch at %0t: got %h expected %h", $time, (act), (exp)); \
        end \
    end

module tb_top;
    logic        clk, rstn, clear_n, oe_n;
    logic        wclk, rclk, wen_n, ren_n, sel_n;
    logic [17:0] wdata, rdata;
    logic        rdata_oe, full_n, empty_n, af_n, ae_n, hf_n, pop_n, chain_in_n;
    int          err_total, total_checks, cycles, n_th, m_th, push_pulses, pop_pulses;

    // Head and pop chain straps tied low, push chain input driven: single-device mode until chain_in_n rises
    dcff_top u_dcff_top (.CLK(clk), .RSTN(rstn), .WCLK(wclk), .RCLK(rclk), .CLEAR_IN_N(clear_n),
        .WRITE_ENABLE_N(wen_n), .READ_ENABLE_N(ren_n), .THRESHOLD_SELECT_N(sel_n), .OUTPUT_ENABLE_N(oe_n),
        .CHAIN_HEAD_N(1'b0), .PUSH_CHAIN_IN_N(chain_in_n), .POP_CHAIN_IN_N(1'b0), .WRITE_DATA(wdata),
        .READ_DATA(rdata), .READ_DATA_OE(rdata_oe), .FULL_N(full_n), .EMPTY_N(empty_n),
        .ALMOST_FULL_N(af_n), .ALMOST_EMPTY_N(ae_n), .PUSH_CHAIN_OUT_N(hf_n), .POP_CHAIN_OUT_N(pop_n));
    dcff_port_model u_dcff_port_model (.clk(clk), .wclk(wclk), .rclk(rclk), .wen_n(wen_n),
        .ren_n(ren_n), .sel_n(sel_n), .data(wdata));

    // 40 ns system clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Chain pulses counted mid-cycle, where the outputs have settled
    always @(negedge clk) begin
        if (chain_in_n && !hf_n) push_pulses++;
        if (!pop_n) pop_pulses++;
    end

    // Hang guard, well above the roughly 10000 cycles of the run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 16000) begin
            err_total++;
            $display("mismatch at %0t: timeout", $time);
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic s_n, input logic e_n, input logic [17:0] d);
        u_dcff_port_model.port_cycle(1'b1, s_n, e_n, d);
    endtask

    task automatic rd(input logic s_n, input logic e_n);
        u_dcff_port_model.port_cycle(1'b0, s_n, e_n, 18'h0_0000);
    endtask

    function automatic logic [17:0] pat(input int i);
        return 18'(i) * 18'h0_0407;
    endfunction

    // Flag levels expected for a stored count
    task automatic chk_flags(input int cnt, input logic e_full, input logic e_empty);
        `CHK(full_n, e_full)
        `CHK(empty_n, e_empty)
        `CHK(af_n, logic'(cnt < 256 - m_th))
        `CHK(hf_n, logic'(cnt <= 128))
        `CHK(ae_n, logic'(cnt > n_th))
    endtask

    initial begin
        rstn    = 1'b0;
        clear_n = 1'b1;
        oe_n    = 1'b0;
        chain_in_n = 1'b0;
        n_th    = 31;
        m_th    = 31;
        repeat (6) @(posedge clk);
        #1;
        rstn = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk_flags(0, 1'b1, 1'b0);
        `CHK(rdata, 18'h0_0000)
        // A lone word waits for a read request
        wr(1'b1, 1'b0, 18'h2_5A5A);
        `CHK(rdata, 18'h0_0000)
        `CHK(empty_n, 1'b0)
        rd(1'b1, 1'b1);
        `CHK(empty_n, 1'b1)
        `CHK(rdata, 18'h0_0000)
        rd(1'b1, 1'b0);
        `CHK(rdata, 18'h2_5A5A)
        `CHK(empty_n, 1'b0)
        rd(1'b1, 1'b0);
        `CHK(rdata, 18'h2_5A5A)
        $display("test no_fall_through done");
        // Threshold defaults, wrap, disabled edge, resume mid-sequence
        rd(1'b0, 1'b0);
        `CHK(rdata, 18'h0_001F)
        rd(1'b0, 1'b0);
        `CHK(rdata, 18'h0_001F)
        wr(1'b0, 1'b0, 18'h3_F007);
        wr(1'b0, 1'b0, 18'h0_00C8);
        wr(1'b0, 1'b0, 18'h0_0003);
        wr(1'b0, 1'b1, 18'h0_0055);
        wr(1'b1, 1'b1, 18'h0_0000);
        wr(1'b0, 1'b0, 18'h0_0064);
        rd(1'b0, 1'b0);
        `CHK(rdata, 18'h0_0003)
        rd(1'b0, 1'b0);
        `CHK(rdata, 18'h0_0064)
        $display("test thresholds done");
        n_th = 3;
        m_th = 100;
        // Fill to full, then one refused write
        for (int i = 1; i <= 256; i++) begin
            wr(1'b1, 1'b0, pat(i));
            chk_flags(i, logic'(i < 256), 1'b0);
        end
        wr(1'b1, 1'b0, 18'h3_FFFF);
        chk_flags(256, 1'b0, 1'b0);
        rd(1'b1, 1'b1);
        chk_flags(256, 1'b0, 1'b1);
        // Drain; full flag waits for a write edge
        for (int i = 1; i <= 256; i++) begin
            rd(1'b1, 1'b0);
            `CHK(rdata, pat(i))
            chk_flags(256 - i, logic'(i > 1), logic'(i < 256));
            if (i == 1) wr(1'b1, 1'b1, 18'h0_0000);
        end
        `CHK(pop_pulses, 0)
        $display("test fill_drain done");
        oe_n = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        `CHK(rdata_oe, 1'b0)
        oe_n = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        `CHK(rdata_oe, 1'b1)
        // Clear with a word stored: pointers, flags and thresholds restart
        wr(1'b1, 1'b0, 18'h1_2345);
        clear_n = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        clear_n = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        n_th = 31;
        m_th = 31;
        chk_flags(0, 1'b1, 1'b0);
        `CHK(rdata, 18'h0_0000)
        rd(1'b0, 1'b0);
        `CHK(rdata, 18'h0_001F)
        rd(1'b0, 1'b0);
        `CHK(rdata, 18'h0_001F)
        wr(1'b1, 1'b0, 18'h0_BEEF);
        rd(1'b1, 1'b1);
        rd(1'b1, 1'b0);
        `CHK(rdata, 18'h0_BEEF)
        $display("test clear done");
        // Chain mode: one pulse on the last-location write, one on its read
        chain_in_n = 1'b1;
        for (int i = 1; i <= 255; i++) begin
            wr(1'b1, 1'b0, pat(i));
        end
        `CHK(push_pulses, 1)
        rd(1'b1, 1'b1);
        for (int i = 1; i <= 255; i++) begin
            rd(1'b1, 1'b0);
            `CHK(rdata, pat(i))
        end
        `CHK(pop_pulses, 1)
        $display("test chain done");
        test_done();
    end
endmodule // tb_top
